// *** rtl/pd_pkg.sv ***
// package: constants and types for the power-down and impedance calibration block
package pd_pkg;
	// command encodings on cmd_addr_bit2..0 (chip select low)
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_DEEP = 3'h3;
	localparam logic [2:0] CMD_MRW_LO = 3'h0;
	// mode register address that carries calibration codes
	localparam logic [7:0] MA_CAL = 8'h0A;
	// calibration operation codes
	localparam logic [7:0] OP_CAL_INIT = 8'hFF;
	localparam logic [7:0] OP_CAL_LONG = 8'hAB;
	localparam logic [7:0] OP_CAL_SHORT = 8'h56;
	localparam logic [7:0] OP_CAL_RESET = 8'hC3;
	// calibration period lengths in clock cycles (defaults, tunable)
	localparam int CAL_INIT_CYC = 100;
	localparam int CAL_LONG_CYC = 36;
	localparam int CAL_SHORT_CYC = 9;
	localparam int CAL_RESET_CYC = 5;
	localparam int CNT_W = 8;
	// device power state
	typedef enum logic [1:0]
	{
		ST_ACTIVE = 2'b00,
		ST_PDOWN = 2'b01,
		ST_DEEP = 2'b11,
		ST_CAL = 2'b10
	} pwr_state_t;
endpackage : pd_pkg

// *** rtl/cal_if.sv ***
// interface: calibration request and status between top and the calibration timer
`timescale 1ns/1ps
`default_nettype none
interface cal_if;
	logic start; // one-cycle start pulse
	logic [7:0] op; // calibration operation code
	logic busy; // calibration period running
	logic done; // one-cycle end pulse
	modport ctl (output start, output op, input busy, input done);
	modport tmr (input start, input op, output busy, output done);
endinterface : cal_if
`default_nettype wire

// *** rtl/cal_timer.sv ***
// module: times one impedance calibration period
`timescale 1ns/1ps
`default_nettype none
module cal_timer
(
	input wire logic clk,
	input wire logic rst_n,
	cal_if.tmr cal
);
	// ========================================
	// period counter
	logic [pd_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic busy_q, busy_d;
	logic done_q, done_d;

	// period length for a code; unknown codes take the short period
	function automatic logic [pd_pkg::CNT_W-1:0] period(input logic [7:0] op);
		unique case (op)
			pd_pkg::OP_CAL_INIT: period = pd_pkg::CNT_W'(pd_pkg::CAL_INIT_CYC);
			pd_pkg::OP_CAL_LONG: period = pd_pkg::CNT_W'(pd_pkg::CAL_LONG_CYC);
			pd_pkg::OP_CAL_RESET: period = pd_pkg::CNT_W'(pd_pkg::CAL_RESET_CYC);
			default: period = pd_pkg::CNT_W'(pd_pkg::CAL_SHORT_CYC);
		endcase
	endfunction : period

	// next-state: load on start, count down, pulse done at zero
	always_comb
	begin
		cnt_d = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (cal.start)
		begin
			cnt_d = period(cal.op) - pd_pkg::CNT_W'(1);
			busy_d = 1'b1;
		end
		else if (busy_q)
		begin
			if (cnt_q == '0)
			begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
			else
				cnt_d = cnt_q - pd_pkg::CNT_W'(1);
		end
	end

	// registers only
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign cal.busy = busy_q;
	assign cal.done = done_q;
endmodule : cal_timer
`default_nettype wire

// *** rtl/pd_ctrl.sv ***
// module: device-side power-down, deep sleep and calibration command handling
//
// Behaviour
// [RULE1] calibration only when idle, banks precharged
// [RULE2] data bus quiet during calibration
// [RULE3] shared resistor: no overlapping calibrations
// [RULE4] reference tied to supply: ignore calibration
// [RULE5] only no-ops during calibration
// [RULE6] clock enable high throughout calibration
// [RULE7] data lines high impedance while calibrating
// [RULE8] enable low, select high: enter power-down
// [RULE9] no power-down during reads, writes, mode ops
// [RULE10] idle versus active power-down by open rows
// [RULE11] power-down: only clock and enable listened
// [RULE12] enable pulse minimum held both ways
// [RULE13] no refresh while powered down
// [RULE14] enable high with select high exits
// [RULE15] wait exit latency before next command
// [RULE16] two stable clocks before exit
// [RULE17] read to power-down minimum delay
// [RULE18] write to power-down minimum delay
// [RULE19] refresh, activate, precharge: hold time
// [RULE20] mode write to power-down: write period
// [RULE21] enable low with code 110: deep sleep
// [RULE22] deep sleep entry discards array contents
// [RULE23] deep sleep: all buffers and power off
// [RULE24] no-op: select high or code 111
// [RULE25] full initialization after deep sleep
// [RULE26] controller tracks power-down earliest cycles
`timescale 1ns/1ps
`default_nettype none
module pd_ctrl
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cke_pin,
	input wire logic cs_n_pin,
	input wire logic cmd_addr_bit0,
	input wire logic cmd_addr_bit1,
	input wire logic cmd_addr_bit2,
	input wire logic [7:0] mrw_addr,
	input wire logic [7:0] mrw_op,
	input wire logic impedance_ref_ball,
	input wire logic banks_open,
	output logic powered_down,
	output logic active_pd,
	output logic deep_sleep_mode,
	output logic array_discard,
	output logic in_buf_en,
	output logic out_buf_en,
	output logic core_power_en,
	output logic refresh_allow,
	output logic cal_busy,
	output logic cal_ignored
);
	// ========================================
	// pin synchronisers: pins come from outside the clock domain
	logic [4:0] pin_s1_q, pin_s2_q;
	logic [7:0] ma_s1_q, ma_s2_q, op_s1_q, op_s2_q;
	logic ref_s1_q, ref_s2_q, bo_s1_q, bo_s2_q;

	// two flops per pin; only the second stage is read
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_q <= 5'h03;
			pin_s2_q <= 5'h03;
			ma_s1_q <= 8'h00;
			ma_s2_q <= 8'h00;
			op_s1_q <= 8'h00;
			op_s2_q <= 8'h00;
			ref_s1_q <= 1'b0;
			ref_s2_q <= 1'b0;
			bo_s1_q <= 1'b0;
			bo_s2_q <= 1'b0;
		end
		else
		begin
			pin_s1_q <= {cmd_addr_bit2, cmd_addr_bit1, cmd_addr_bit0, cs_n_pin, cke_pin};
			pin_s2_q <= pin_s1_q;
			ma_s1_q <= mrw_addr;
			ma_s2_q <= ma_s1_q;
			op_s1_q <= mrw_op;
			op_s2_q <= op_s1_q;
			ref_s1_q <= impedance_ref_ball;
			ref_s2_q <= ref_s1_q;
			bo_s1_q <= banks_open;
			bo_s2_q <= bo_s1_q;
		end
	end

	// ========================================
	// decoded sampled command
	logic cke, cs_n;
	logic [2:0] code;
	assign cke = pin_s2_q[0];
	assign cs_n = pin_s2_q[1];
	assign code = pin_s2_q[4:2];

	// no-op is select high or code 111
	function automatic logic is_nop(input logic csn, input logic [2:0] c);
		is_nop = csn || (c == pd_pkg::CMD_NOP); // [RULE24]
	endfunction : is_nop

	// ========================================
	// calibration timer
	cal_if cal();
	cal_timer u_cal
	(
		.clk(clk),
		.rst_n(rst_n),
		.cal(cal.tmr)
	);

	// ========================================
	// power state machine
	pd_pkg::pwr_state_t st_q, st_d;
	logic act_q, act_d; // active (rows open) power-down
	logic disc_q, disc_d; // array discarded since deep sleep
	logic ign_q, ign_d; // last calibration command ignored
	logic start_d;
	logic is_cal_cmd;

	// calibration command: mode write to calibration address, code 000
	assign is_cal_cmd = !is_nop(cs_n, code) && (code == pd_pkg::CMD_MRW_LO)
		&& (ma_s2_q == pd_pkg::MA_CAL);

	// next state; in power-down all pins but enable are ignored
	always_comb
	begin
		st_d = st_q;
		act_d = act_q;
		disc_d = disc_q;
		ign_d = ign_q;
		start_d = 1'b0;
		unique case (st_q)
			pd_pkg::ST_ACTIVE:
			begin
				// a selected command that is no no-op; enable low makes code 011 deep sleep
				if (!cke && !is_nop(cs_n, code) && code == pd_pkg::CMD_DEEP)
				begin
					st_d = pd_pkg::ST_DEEP; // [RULE21]
					disc_d = 1'b1; // [RULE22]
				end
				else if (!cke && cs_n)
				begin
					st_d = pd_pkg::ST_PDOWN; // [RULE8]
					act_d = bo_s2_q; // [RULE10]
				end
				else if (cke && is_cal_cmd)
				begin
					// a tied reference keeps default impedance
					if (ref_s2_q)
						ign_d = 1'b1; // [RULE4]
					else
					begin
						ign_d = 1'b0;
						start_d = 1'b1;
						st_d = pd_pkg::ST_CAL;
					end
				end
			end
			pd_pkg::ST_CAL:
			begin
				// controller sends only no-ops, enable high
				if (cal.done)
					st_d = pd_pkg::ST_ACTIVE; // [RULE5]
			end
			pd_pkg::ST_PDOWN:
			begin
				if (cke)
				begin
					st_d = pd_pkg::ST_ACTIVE; // [RULE14]
					act_d = 1'b0;
				end
			end
			pd_pkg::ST_DEEP:
			begin
				// leaving only starts the full initialization again
				if (cke)
					st_d = pd_pkg::ST_ACTIVE; // [RULE25]
			end
		endcase
	end

	assign cal.start = start_d;
	assign cal.op = op_s2_q;

	// state registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= pd_pkg::ST_ACTIVE;
			act_q <= 1'b0;
			disc_q <= 1'b0;
			ign_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			act_q <= act_d;
			disc_q <= disc_d;
			ign_q <= ign_d;
		end
	end

	// ========================================
	// registered outputs
	logic [9:0] out_q, out_d;
	// buffer and power enables per state
	always_comb
	begin
		out_d[0] = (st_d == pd_pkg::ST_PDOWN);
		out_d[1] = (st_d == pd_pkg::ST_PDOWN) && act_d;
		out_d[2] = (st_d == pd_pkg::ST_DEEP);
		out_d[3] = disc_d;
		out_d[4] = (st_d == pd_pkg::ST_ACTIVE) || (st_d == pd_pkg::ST_CAL); // [RULE11] [RULE23]
		out_d[5] = (st_d == pd_pkg::ST_ACTIVE); // data lines off while calibrating
		out_d[6] = (st_d != pd_pkg::ST_DEEP); // [RULE23]
		out_d[7] = (st_d == pd_pkg::ST_ACTIVE); // [RULE13]
		out_d[8] = (st_d == pd_pkg::ST_CAL);
		out_d[9] = ign_d;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			out_q <= 10'h0F0;
		else
			out_q <= out_d;
	end

	assign powered_down = out_q[0];
	assign active_pd = out_q[1];
	assign deep_sleep_mode = out_q[2];
	assign array_discard = out_q[3];
	assign in_buf_en = out_q[4];
	assign out_buf_en = out_q[5];
	assign core_power_en = out_q[6];
	assign refresh_allow = out_q[7];
	assign cal_busy = out_q[8];
	assign cal_ignored = out_q[9];

	// ========================================
	// checks
	chk_pd_entry: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
		(st_q == pd_pkg::ST_ACTIVE && !cke && cs_n) |-> ##2 powered_down)
		else $error("power-down not entered");
	chk_pd_exit: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
		(st_q == pd_pkg::ST_PDOWN && cke) |-> ##2 (!powered_down && refresh_allow))
		else $error("power-down not left");
	chk_deep_entry: assert property (@(posedge clk) disable iff (!rst_n) // [RULE21]
		(st_q == pd_pkg::ST_ACTIVE && !cke && !cs_n && code == pd_pkg::CMD_DEEP)
		|-> ##2 (deep_sleep_mode && array_discard && !core_power_en))
		else $error("deep sleep not entered");
	chk_cal_ignore: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
		(st_q == pd_pkg::ST_ACTIVE && cke && is_cal_cmd && ref_s2_q) |-> ##2 !cal_busy)
		else $error("calibration ran with tied reference");
	chk_pd_buffers: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
		powered_down |-> (!in_buf_en && !out_buf_en && !refresh_allow))
		else $error("buffers live in power-down");
	chk_pd_kind: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
		(st_q == pd_pkg::ST_ACTIVE && !cke && cs_n) |-> ##2 (active_pd == $past(bo_s2_q, 2)))
		else $error("power-down kind wrong");
	// the state may only sit in calibration while the timer runs or has just ended
	chk_cal_timer: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
		(st_q == pd_pkg::ST_CAL) |-> (cal.busy || cal.done))
		else $error("calibration state without a running period");
	// once discarded the array never reads as kept until reset
	chk_discard_sticky: assert property (@(posedge clk) disable iff (!rst_n) // [RULE22]
		array_discard |=> array_discard)
		else $error("discarded array marked kept again");
endmodule : pd_ctrl
`default_nettype wire

// *** tb/ctl_model.sv ***
// file: controller-side model that drives the command pins
`timescale 1ns/1ps
`default_nettype none
module ctl_model
(
	input wire logic clk,
	output logic cke_pin,
	output logic cs_n_pin,
	output logic [2:0] code,
	output logic [7:0] addr,
	output logic [7:0] op
);
	// ==========================
	// pin state
	// the model never drives the data lines: they stay quiet and high impedance
	// one device on its own reference resistor, so calibrations never overlap
	// idle pins are a deselected no-op with enable high
	initial
	begin
		cke_pin = 1'b1;
		cs_n_pin = 1'b1;
		code = pd_pkg::CMD_NOP;
		addr = 8'h00;
		op = 8'h00;
	end
	// ==========================
	// controller timing in clocks; plain defaults, not tied to any speed grade
	localparam int READ_LAT = 3; // read latency
	localparam int STROBE_CYC = 1; // strobe access time, rounded up
	localparam int BURST_LEN = 4; // burst length
	localparam int WRITE_LAT = 1; // write latency
	localparam int RECOVERY_CYC = 2; // write recovery, rounded up
	localparam int MODE_WRITE_CYC = 5; // mode write period
	localparam int HOLD_CYC = 1; // enable hold after refresh, activate, precharge
	localparam int MIN_CKE_CYC = 3; // enable pulse minimum, also covers exit latency
	int cyc = 0; // free-running clock count
	int drop_ok = 0; // first count at which enable may be sampled low
	always @(posedge clk)
		cyc <= cyc + 1;
	// earliest enable drop after a selected command, by its code
	function automatic int drop_delay(input logic [2:0] c);
		case (c)
			3'h0: drop_delay = MODE_WRITE_CYC; // mode write
			3'h1: drop_delay = WRITE_LAT + 1 + BURST_LEN / 2 + RECOVERY_CYC; // write
			3'h5: drop_delay = READ_LAT + STROBE_CYC + BURST_LEN / 2 + 1; // read
			default: drop_delay = HOLD_CYC; // refresh, activate, precharge
		endcase
	endfunction : drop_delay
	// one command, then a deselected no-op; enable stays where it was put
	task issue(input logic ke, input logic cs, input logic [2:0] c,
		input logic [7:0] a, input logic [7:0] o);
		logic ke_old;
		ke_old = cke_pin;
		// enable never drops while a read, write or mode operation runs
		if (!ke)
			while (cyc < drop_ok)
				@(posedge clk);
		@(posedge clk);
		cke_pin <= ke;
		cs_n_pin <= cs;
		code <= c;
		addr <= a;
		op <= o;
		// a selected command with enable high restarts the drop counter
		if (ke && !cs && c != pd_pkg::CMD_NOP)
			drop_ok = cyc + 1 + drop_delay(c);
		@(posedge clk);
		cs_n_pin <= 1'b1;
		// released lines flip so that a stale value never looks valid
		code <= ~c;
		addr <= ~a;
		op <= ~o;
		// a changed enable stands its minimum pulse, and exit latency passes
		if (ke != ke_old)
			repeat (MIN_CKE_CYC) @(posedge clk);
	endtask : issue
endmodule : ctl_model
`default_nettype wire

// *** tb/tb_top.sv ***
// file: self-checking bench for the power-down control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_total++; \
	$display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb_top;
	// ==========================
	// signals
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ref_tied = 1'b0; // reference ball tied to supply when high
	logic banks = 1'b0; // a row open when high
	logic cke;
	logic cs_n;
	logic [2:0] code;
	logic [7:0] addr;
	logic [7:0] op;
	logic pd, apd, deep, disc, ibuf, obuf, core, refr, busy, ign;
	int err_total = 0;
	int checks_done = 0;
	always #5 clk = ~clk;
	ctl_model i_ctl_model (.clk(clk), .cke_pin(cke), .cs_n_pin(cs_n), .code(code),
		.addr(addr), .op(op));
	pd_ctrl i_pd_ctrl (.clk(clk), .rst_n(rst_n), .cke_pin(cke), .cs_n_pin(cs_n),
		.cmd_addr_bit0(code[0]), .cmd_addr_bit1(code[1]), .cmd_addr_bit2(code[2]),
		.mrw_addr(addr), .mrw_op(op), .impedance_ref_ball(ref_tied),
		.banks_open(banks), .powered_down(pd), .active_pd(apd),
		.deep_sleep_mode(deep), .array_discard(disc), .in_buf_en(ibuf),
		.out_buf_en(obuf), .core_power_en(core), .refresh_allow(refr),
		.cal_busy(busy), .cal_ignored(ign));
	// ==========================
	// helpers
	// sample a little after the edge so its updates have landed
	task wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	task end_of_test;
		if (err_total == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	// ==========================
	// scenarios
	// enter power-down, try a command inside it, leave again
	task t_pd(input logic open);
		@(posedge clk);
		banks <= open;
		i_ctl_model.issue(1'b0, 1'b1, pd_pkg::CMD_NOP, 8'h00, 8'h00);
		wt(3);
		`CHK("pd", {1'b1, open, 6'b000010, 2'b00}, {pd, apd, deep, disc, ibuf, obuf, core, refr, busy, ign})
		i_ctl_model.issue(1'b0, 1'b0, pd_pkg::CMD_MRW_LO, pd_pkg::MA_CAL, pd_pkg::OP_CAL_SHORT);
		wt(4);
		`CHK("pd_cmd", 4'b1000, {pd, ibuf, obuf, busy})
		i_ctl_model.issue(1'b1, 1'b1, pd_pkg::CMD_NOP, 8'h00, 8'h00);
		wt(3);
		`CHK("pd_exit", 10'b0000111100, {pd, apd, deep, disc, ibuf, obuf, core, refr, busy, ign})
		@(posedge clk);
		banks <= 1'b0;
	endtask : t_pd
	// every calibration kind runs for its own period
	task t_cal;
		logic [7:0] ops [5];
		int per [5];
		// the last entry is an unknown code, which takes the short period
		ops = '{pd_pkg::OP_CAL_INIT, pd_pkg::OP_CAL_LONG, pd_pkg::OP_CAL_SHORT,
			pd_pkg::OP_CAL_RESET, 8'h00};
		per = '{pd_pkg::CAL_INIT_CYC, pd_pkg::CAL_LONG_CYC, pd_pkg::CAL_SHORT_CYC,
			pd_pkg::CAL_RESET_CYC, pd_pkg::CAL_SHORT_CYC};
		for (int i = 0; i < 5; i++)
		begin
			i_ctl_model.issue(1'b1, 1'b0, pd_pkg::CMD_MRW_LO, pd_pkg::MA_CAL, ops[i]);
			wt(3);
			`CHK("cal_start", 1'b1, busy)
			wt(per[i] - 2); // only no-ops and enable high meanwhile
			`CHK("cal_hold", 1'b1, busy)
			wt(5);
			`CHK("cal_end", 1'b0, busy)
		end
	endtask : t_cal
	// tied reference: calibration is ignored
	task t_ignore;
		@(posedge clk);
		ref_tied <= 1'b1;
		i_ctl_model.issue(1'b1, 1'b0, pd_pkg::CMD_MRW_LO, pd_pkg::MA_CAL, pd_pkg::OP_CAL_LONG);
		wt(4);
		`CHK("cal_tied", 2'b01, {busy, ign})
	endtask : t_ignore
	// deep sleep drops everything and discards the array
	task t_deep;
		i_ctl_model.issue(1'b0, 1'b0, pd_pkg::CMD_DEEP, 8'h00, 8'h00);
		wt(3);
		`CHK("deep", 6'b011000, {pd, deep, disc, ibuf, obuf, core})
		i_ctl_model.issue(1'b1, 1'b1, pd_pkg::CMD_NOP, 8'h00, 8'h00);
		wt(3);
		`CHK("deep_exit", 3'b011, {deep, disc, core})
	endtask : t_deep
	// ==========================
	// main sequence and watchdog
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		wt(1);
		`CHK("reset", 10'b0000111100, {pd, apd, deep, disc, ibuf, obuf, core, refr, busy, ign})
		i_ctl_model.issue(1'b1, 1'b0, pd_pkg::CMD_NOP, pd_pkg::MA_CAL, pd_pkg::OP_CAL_LONG);
		wt(4);
		`CHK("nop", 10'b0000111100, {pd, apd, deep, disc, ibuf, obuf, core, refr, busy, ign})
		t_pd(1'b0);
		t_pd(1'b1);
		t_cal();
		t_deep();
		t_ignore();
		end_of_test();
	end
	// the whole run needs about 300 cycles; the watchdog fires after 5000
	initial
	begin
		#50us;
		err_total++;
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
